// ### rtl/serial_loop_pkg.sv
/*
 Constants for the serial and current-loop port logic: addresses, bit
 positions, reset values.
 Assumes an 8-bit backplane I/O space and a 4-bit latch per port.
*/
package serial_loop_pkg;
   localparam logic [7:0] DEFAULT_SERIAL_ADDR = 8'hC0;
   localparam logic [7:0] DEFAULT_LOOP_ADDR = 8'hC1;
   localparam int LATCH_W = 4;
   localparam logic [3:0] LATCH_RESET = 4'h0;
   localparam logic [3:0] UPPER_NIBBLE_READ = 4'hF;
   // loop port bits
   localparam int LOOP_DATA_BIT = 0;
   localparam int LOOP_TAPE_BIT = 1;
   localparam int LOOP_CABLE_BIT = 1;
   localparam int LOOP_SERIAL_CABLE_BIT = 2;
   // serial port bits, data terminal wiring
   localparam int SER_RX_BIT = 0;
   localparam int SER_CTS_BIT = 1;
   localparam int SER_CD_BIT = 2;
   localparam int SER_DSR_BIT = 3;
   localparam int SER_TX_BIT = 0;
   localparam int SER_RTS_BIT = 1;
   localparam int SER_SEC_TX_BIT = 2;
   localparam int SER_DTR_BIT = 3;
endpackage

// ### rtl/port_latch_if.sv
/*
 Interface carrying one 4-bit output latch write and its held value.
 Assumes a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface port_latch_if;
   logic load;
   logic [3:0] wdata;
   logic [3:0] q;
   modport ctrl (output load, output wdata, input q);
   modport latch (input load, input wdata, output q);
endinterface
`default_nettype wire

// ### rtl/port_latch.sv
/*
 One 4-bit latching output port, cleared by reset.
 Assumes load is a one-cycle pulse from the strobe edge detect.
*/
`timescale 1ns/1ps
`default_nettype none
module port_latch (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // latch port
   port_latch_if.latch lp
);
   import serial_loop_pkg::*;
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         lp.q <= LATCH_RESET;
      end else if (lp.load) begin
         lp.q <= lp.wdata;
      end
   end
endmodule
`default_nettype wire

// ### rtl/serial_loop_port_logic.sv
/*
 Port logic of a serial-line and current-loop card on an 8-bit bus.
 Assumes bus strobes are synchronous to i_clk_sys and active low; the
 address pair base is set by i_base_addr (even address = serial port).
*/
// What this block does
// - loop transmit and tape drive from 4-bit latch; loop receive read on demand
// - loop input and output share one remappable address, default C1
// - loop read: bits 7-4 one, bit2 serial cable, bit1 loop cable, bit0 data
// - tape relay drive on while latched bit 1 is one, off at reset
// - loop transmit current flows while latched bit 0 is zero
// - input bit 0 reports received loop data, one when marking
// - input bit 1 is one when loop cable grounds interlock pin
// - system reset clears both output latches
// - system reset leaves gated input ports live and untouched
// - A7-A1 select the card, A0 picks serial (even) or loop (odd)
// - read strobe gates input port, write strobe loads latch
// - one input port and one 4-bit latch per address, low data lines
// - default pair C0/C1, reconfigurable to any pair starting at an even address
// - serial port bits DSR, CD, CTS, RXD read; DTR, STX, RTS, TXD written
`timescale 1ns/1ps
`default_nettype none
module serial_loop_port_logic (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // address pair strap
   input wire logic [7:0] i_base_addr,
   // backplane bus
   input wire logic [7:0] i_addr,
   input wire logic i_iorq_n,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic [7:0] i_data,
   output logic [7:0] o_data,
   output logic o_data_oe,
   // serial line side, already translated to logic levels
   input wire logic i_serial_rx,
   input wire logic i_serial_cts,
   input wire logic i_serial_cd,
   input wire logic i_serial_dsr,
   input wire logic i_serial_cable_present,
   output logic o_serial_tx,
   output logic o_serial_rts,
   output logic o_serial_sec_tx,
   output logic o_serial_dtr,
   // current loop side
   input wire logic i_current_loop_line_rx,
   input wire logic i_loop_cable_present,
   output logic o_current_loop_line_tx_on,
   output logic o_tape_drive_on
);
   import serial_loop_pkg::*;

   port_latch_if serial_lp ();
   port_latch_if loop_lp ();

   logic card_sel;
   logic is_loop;
   logic wr_n_d;
   logic sel_d;
   logic loop_d;
   logic [3:0] data_d;
   logic wr_rise;
   logic [7:0] next_rdata;

   // A0 ignored for the card match; the pair is base with A0 cleared
   assign card_sel = (i_addr[7:1] == i_base_addr[7:1]) && !i_iorq_n;
   assign is_loop = i_addr[0];

   // write captured on the strobe's rising edge using the request seen while it was low
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_n_d <= 1'b1;
         sel_d <= 1'b0;
         loop_d <= 1'b0;
         data_d <= LATCH_RESET;
      end else begin
         wr_n_d <= i_wr_n;
         sel_d <= card_sel;
         loop_d <= is_loop;
         data_d <= i_data[3:0];
      end
   end

   assign wr_rise = i_wr_n && !wr_n_d && sel_d;

   assign serial_lp.load = wr_rise && !loop_d;
   assign serial_lp.wdata = data_d;
   assign loop_lp.load = wr_rise && loop_d;
   assign loop_lp.wdata = data_d;

   port_latch u_serial_latch (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .lp(serial_lp.latch)
   );

   port_latch u_loop_latch (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .lp(loop_lp.latch)
   );

   // input ports are gated live lines, reset does not touch them
   always_comb begin
      next_rdata = {UPPER_NIBBLE_READ, 4'h0};
      if (is_loop) begin
         next_rdata[LOOP_DATA_BIT] = i_current_loop_line_rx;
         next_rdata[LOOP_CABLE_BIT] = i_loop_cable_present;
         next_rdata[LOOP_SERIAL_CABLE_BIT] = i_serial_cable_present;
      end else begin
         next_rdata[SER_RX_BIT] = i_serial_rx;
         next_rdata[SER_CTS_BIT] = i_serial_cts;
         next_rdata[SER_CD_BIT] = i_serial_cd;
         next_rdata[SER_DSR_BIT] = i_serial_dsr;
      end
   end

   // data register has no reset on purpose; it loads next_rdata on every clock, during reset too
   always_ff @(posedge i_clk_sys) begin
      o_data <= next_rdata;
   end

   // enable set the clock after the read strobe is seen on a decoded request
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_data_oe <= 1'b0;
      end else begin
         o_data_oe <= card_sel && !i_rd_n;
      end
   end

   assign o_serial_tx = serial_lp.q[SER_TX_BIT];
   assign o_serial_rts = serial_lp.q[SER_RTS_BIT];
   assign o_serial_sec_tx = serial_lp.q[SER_SEC_TX_BIT];
   assign o_serial_dtr = serial_lp.q[SER_DTR_BIT];
   // cleared latch means current flows: line marks after reset
   assign o_current_loop_line_tx_on = !loop_lp.q[LOOP_DATA_BIT];
   assign o_tape_drive_on = loop_lp.q[LOOP_TAPE_BIT];
endmodule
`default_nettype wire

// ### tb/slp_properties.sv
/* port logic assertions; sees only the top ports, bound from tb */
`timescale 1ns/1ps
`default_nettype none
module slp_properties (
   input wire logic i_clk_sys, i_rstn, i_iorq_n, i_rd_n, i_wr_n, o_data_oe, o_serial_tx,
   input wire logic i_loop_cable_present, i_current_loop_line_rx,
   input wire logic o_tape_drive_on, o_current_loop_line_tx_on,
   input wire logic [7:0] i_base_addr, i_addr, i_data, o_data
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   // bit 0 of the base is ignored: the pair always starts even
   wire logic s = !i_iorq_n && i_addr[7:1] == i_base_addr[7:1];
   wire logic w = s && !i_wr_n && i_addr[0];
   wire logic g = s && !i_rd_n;
   a_tape_on: assert property (w ##1 i_wr_n |=> o_tape_drive_on == $past(i_data[1], 2))
      else $error("tape drive");
   a_loop_tx: assert property (w ##1 i_wr_n |=> o_current_loop_line_tx_on != $past(i_data[0], 2))
      else $error("loop tx");
   a_rx_data: assert property (g && i_addr[0] |=> o_data[0] == $past(i_current_loop_line_rx))
      else $error("rx data");
   a_loop_cable: assert property (g && i_addr[0] |=> o_data[1] == $past(i_loop_cable_present))
      else $error("cable");
   a_read_gate: assert property (o_data_oe == $past(g)) else $error("oe");
   a_upper_ones: assert property (o_data_oe |-> o_data[7:4] == 4'hF) else $error("upper");
   a_latch_hold: assert property (!$past(w, 2) |-> $stable(o_tape_drive_on))
      else $error("hold");
   a_reset_clear: assert property (disable iff (1'b0) !i_rstn |-> !o_tape_drive_on
      && o_current_loop_line_tx_on && !o_serial_tx && !o_data_oe) else $error("reset");
endmodule
`default_nettype wire

// ### tb/cpu_card.sv
/* processor card bus model; drives at the falling edge of i_clk_sys */
`timescale 1ns/1ps
`default_nettype none
module cpu_card (
   input wire logic i_clk_sys,
   output logic [7:0] o_a,
   output logic [7:0] o_d,
   output logic [2:0] o_ctl
);
   initial {o_a, o_d, o_ctl} = 19'h7;
   task automatic cycle(input logic [7:0] a, d, input logic rd);
      @(negedge i_clk_sys) {o_a, o_d, o_ctl} = {a, d, 1'b0, !rd, rd};
      // released address and data lines show the inverse, never the last value
      @(negedge i_clk_sys) {o_a, o_d, o_ctl} = {~a, ~d, 3'h7};
   endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
/* self-checking bench; read data is answered one cycle after the strobe */
`timescale 1ns/1ps
`default_nettype none
module tb;
   // reset starts unknown and falls at 1 ns so the asynchronous clear really fires
   logic c = 0, n, oe, ltx, tp, tx, rt, sc, dt;
   logic [6:0] l = 0;
   logic [2:0] ctl;
   logic [7:0] b = 8'hC0, a, d, rd, q[$];
   logic [31:0] r = 97855;
   int fails = 0, num_checks = 0;
   initial forever #12.5 c = ~c;
   cpu_card u_cpu (.i_clk_sys(c), .o_a(a), .o_d(d), .o_ctl(ctl));
   serial_loop_port_logic uut (.i_clk_sys(c), .i_rstn(n), .i_base_addr(b), .i_addr(a),
      .i_iorq_n(ctl[2]), .i_rd_n(ctl[1]), .i_wr_n(ctl[0]), .i_data(d), .o_data(rd),
      .o_data_oe(oe), .i_serial_rx(l[0]), .i_serial_cts(l[1]), .i_serial_cd(l[2]),
      .i_serial_dsr(l[3]), .i_serial_cable_present(l[4]), .o_serial_tx(tx), .o_serial_rts(rt),
      .o_serial_sec_tx(sc), .o_serial_dtr(dt), .i_current_loop_line_rx(l[5]),
      .i_loop_cable_present(l[6]), .o_current_loop_line_tx_on(ltx), .o_tape_drive_on(tp));
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input string s, input logic [7:0] e, v);
      num_checks++;
      if (v !== e) begin
         fails++;
         $display("mismatch %s: expected %h seen %h", s, e, v);
      end
   endtask
   task automatic rdp(input logic [7:0] ad, e);
      q.push_back(e);
      u_cpu.cycle(ad, 8'h00, 1'b1);
   endtask
   always @(negedge c) if (oe === 1'b1) chk("read", q.pop_front(), rd);
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #20us fails++;
      conclude;
   end
   initial begin
      #1 n = 0;
      repeat (8) @(negedge c);
      n = 1;
      for (int i = 0; i < 12; i++) begin
         r = lfsr(r);
         if (i > 5) b = r[31:24];
         @(negedge c) l = r[6:0];
         u_cpu.cycle(b | 8'h01, r[15:8], 1'b0);
         u_cpu.cycle(b & 8'hFE, r[23:16], 1'b0);
         // an unmapped write must leave both latches alone
         u_cpu.cycle(b ^ 8'h80, 8'hFF, 1'b0);
         chk("loop", {6'h00, r[9:8]}, {6'h00, tp, !ltx});
         chk("serial", {4'h0, r[19:16]}, {4'h0, dt, sc, rt, tx});
         rdp(b | 8'h01, {5'h1E, l[4], l[6], l[5]});
         rdp(b & 8'hFE, {4'hF, l[3:0]});
      end
      @(negedge c) #1 n = 0;
      #1 chk("reset", 8'h01, {dt, sc, rt, tx, 2'b00, tp, ltx});
      @(negedge c) n = 1;
      rdp(b | 8'h01, {5'h1E, l[4], l[6], l[5]});
      repeat (2) @(negedge c);
      conclude;
   end
endmodule
bind serial_loop_port_logic slp_properties chk_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
   .i_iorq_n(i_iorq_n), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .o_data_oe(o_data_oe),
   .o_serial_tx(o_serial_tx), .i_loop_cable_present(i_loop_cable_present),
   .i_current_loop_line_rx(i_current_loop_line_rx), .o_tape_drive_on(o_tape_drive_on),
   .o_current_loop_line_tx_on(o_current_loop_line_tx_on), .i_base_addr(i_base_addr),
   .i_addr(i_addr), .i_data(i_data), .o_data(o_data));
`default_nettype wire
